/* File: rtl/mic_pkg.sv */
// How it works
// - Entry waits for the current instruction end
// - Entry pushes program counter, index, accumulator, flags
// - Entry sets the global mask bit
// - Entry loads program counter from source vector
// - Return pops all registers, restoring mask bit
// - Maskable requests serviced only while unmasked
// - Running service routine blocks other maskable requests
// - Fixed priority: reset, trap, vectors 0..13
// - Trap is taken whatever the mask
// - Every maskable source wakes from wait mode; a trap does not
// - Only reset, vector 1, externals end halt
// - Time base and security share vector 1; externals 2-5
// - Serial, timers, async serial, data memory: vectors 7-11
// - External vector taken when event seen, in rising mode with level still high, and unmasked
// - Edge requests latched, cleared on routine entry
// - Participating pins ANDed before the detector
// - Any low participating pin pulls the ANDed group level low
// - Peripheral request needs unmasked and enabled
// - Peripheral request cleared by clear sequence
// - Clear sequence discards a latched pending request
package mic_pkg;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] REG_SENS = 8'h00;  // External sensitivity, 2 bits a group
   localparam logic [7:0] REG_PINEN = 8'h04; // Pins configured as interrupt inputs
   localparam logic [7:0] REG_STAT = 8'h08;  // Pending requests and mode, read only
   localparam logic [7:0] SENS_RST = 8'h00;
   localparam logic [15:0] PINEN_RST = 16'h0000;
   localparam int STAT_IBIT = 16;  // Mask bit position in status
   localparam int STAT_WAIT = 17;
   localparam int STAT_HALT = 18;
   localparam int STAT_BUSY = 19;

   // ****************************************
   // Vectors and stack
   // ****************************************
   localparam logic [3:0] VEC_TRAP = 4'he;   // Codes 0..13 are the maskable slots
   localparam logic [3:0] VEC_RESET = 4'hf;
   localparam logic [15:0] ADDR_RESET = 16'hfffe;
   localparam logic [15:0] ADDR_TRAP = 16'hfffc;
   localparam logic [15:0] ADDR_VEC0 = 16'hfffa; // Slot n sits at this minus 2n
   localparam logic [15:0] SP_RST = 16'h01ff;
   localparam int CC_IBIT = 3;               // Mask bit inside the flag register
   localparam logic [7:0] CC_RST = 8'h08;
   localparam logic [2:0] CTX_BYTES = 3'h4;  // Last byte index of a saved frame

   // ****************************************
   // Sensitivity codes
   // ****************************************
   localparam logic [1:0] SENS_LOW = 2'h0;
   localparam logic [1:0] SENS_RISE = 2'h1;
   localparam logic [1:0] SENS_FALL = 2'h2;
   localparam logic [1:0] SENS_BOTH = 2'h3;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PUSH = 3'b001,
      ST_VECH = 3'b010,
      ST_VECL = 3'b011,
      ST_POP = 3'b100
   } mic_state_t;

   // CPU context exchanged with the core
   typedef struct packed {
      logic [15:0] pc;
      logic [7:0] x;
      logic [7:0] a;
      logic [7:0] cc;
   } mic_ctx_t;

   // Whole state of the controller
   typedef struct packed {
      mic_state_t st;
      logic [2:0] cnt;
      logic [3:0] vec;
      logic [15:0] sp;
      logic ibit;
      logic trap_p;
      logic slp;
      logic hlt;
      logic go;
      logic wake;
      mic_ctx_t ctx;
      logic [6:0] plat;
      logic [6:0] pflag_d;
      logic [15:0] s1;
      logic [15:0] s2;
      logic [15:0] s3;
      logic [15:0] pf;
      logic [3:0] glev_d;
      logic [3:0] elat;
      logic [7:0] sens;
      logic [15:0] pinen;
      logic [31:0] prdata;
   } mic_st_t;

endpackage : mic_pkg

/* File: rtl/mic_ctrl.sv */
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module mic_ctrl (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // CPU core
   input wire logic instr_end_i,
   input wire logic trap_i,
   input wire logic interrupt_return_instruction_i,
   input wire logic wait_i,
   input wire logic halt_i,
   input wire logic mask_set_i,
   input wire logic mask_clr_i,
   input wire mic_pkg::mic_ctx_t ctx_i,
   output mic_pkg::mic_ctx_t ctx_o,
   output logic ctx_load_o,
   output logic mask_o,
   output logic wake_o,
   output logic wait_o,
   output logic halt_o,
   // Stack and vector memory port
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [15:0] mem_addr_o,
   output logic [7:0] mem_wdata_o,
   input wire logic [7:0] mem_rdata_i,
   input wire logic mem_ack_i,
   // Peripheral sources: 0 time base, 1 clock security, 2 SPI,
   // 3 timer A, 4 timer B, 5 async serial, 6 data memory
   input wire logic [6:0] src_flag_i,
   input wire logic [6:0] src_en_i,
   input wire logic [6:0] src_clr_i,
   // External pins, four per group
   input wire logic [15:0] ext_pin_i
);

   // ****************************************
   // Declarations
   // ****************************************
   mic_pkg::mic_st_t s_r;     // Registered state
   mic_pkg::mic_st_t s_nxt;   // Next state
   logic [3:0] glev;          // ANDed group levels
   logic [3:0] gany;          // Group has at least one pin enabled
   logic [3:0] gev;           // Edge event per group
   logic [3:0] ereq;          // External requests
   logic [13:0] req;          // Requests per vector slot
   logic [13:0] hreq;         // Requests able to end halt
   logic [13:0] wreq;         // Requests considered now
   logic [3:0] pick;          // Winning slot
   logic [15:0] vaddr;        // Vector address of s_r.vec
   logic [6:0] pact;          // Enabled peripheral requests
   logic take;                // A maskable request may enter
   logic sel_a;               // APB access phase

   // ****************************************
   // External detection per group
   // ****************************************
   for (genvar g = 0; g < 4; g++) begin : g_ext
      logic [3:0] en;
      logic [3:0] lv;
      logic [1:0] md;
      assign en = s_r.pinen[4*g+3:4*g];
      assign lv = s_r.pf[4*g+3:4*g];
      assign md = s_r.sens[2*g+1:2*g];
      assign gany[g] = |en;
      // Pins not used as interrupts count as high
      assign glev[g] = gany[g] & (&(lv | ~en));
      // Edge events on the ANDed level
      always_comb begin
         case (md)
            mic_pkg::SENS_RISE: gev[g] = glev[g] & ~s_r.glev_d[g];
            mic_pkg::SENS_FALL: gev[g] = gany[g] & ~glev[g] & s_r.glev_d[g];
            mic_pkg::SENS_BOTH: gev[g] = gany[g] & (glev[g] ^ s_r.glev_d[g]);
            default: gev[g] = 1'b0;
         endcase
      end
      // Low level is live, edges come from the latch
      always_comb begin
         case (md)
            mic_pkg::SENS_LOW: ereq[g] = gany[g] & ~glev[g];
            mic_pkg::SENS_RISE: ereq[g] = s_r.elat[g] & glev[g];
            default: ereq[g] = s_r.elat[g];
         endcase
      end
   end

   // ****************************************
   // Request map and priority
   // ****************************************
   // Latched peripheral pending bits pass only when enabled
   assign pact = s_r.plat & src_en_i;
   // Empty slots are tied off
   assign req = {2'b00, pact[6:2], 1'b0, ereq, pact[0] | pact[1], 1'b0};
   // Halt ends only on vector 1 and the externals
   assign hreq = req & 14'h003e;
   assign wreq = s_r.hlt ? hreq : req;

   // Lowest slot number wins
   always_comb begin
      pick = 4'h0;
      for (int i = 13; i >= 0; i--) begin
         if (wreq[i]) begin
            pick = 4'(i);
         end
      end
   end

   // Vector address for the slot being served
   always_comb begin
      case (s_r.vec)
         mic_pkg::VEC_RESET: vaddr = mic_pkg::ADDR_RESET;
         mic_pkg::VEC_TRAP: vaddr = mic_pkg::ADDR_TRAP;
         default: vaddr = mic_pkg::ADDR_VEC0 - {11'h000, s_r.vec, 1'b0};
      endcase
   end

   // Maskable entry needs a clear mask bit
   assign take = (|wreq) & ~s_r.ibit;
   assign sel_a = psel_i & penable_i;

   // ****************************************
   // Memory port
   // ****************************************
   // Address mux reads flops only
   always_comb begin
      mem_req_o = s_r.st != mic_pkg::ST_IDLE;
      mem_we_o = s_r.st == mic_pkg::ST_PUSH;
      mem_wdata_o = s_r.ctx.cc;
      case (s_r.st)
         mic_pkg::ST_PUSH: mem_addr_o = s_r.sp;
         mic_pkg::ST_POP: mem_addr_o = s_r.sp + 16'h0001;
         mic_pkg::ST_VECH: mem_addr_o = vaddr;
         mic_pkg::ST_VECL: mem_addr_o = vaddr + 16'h0001;
         default: mem_addr_o = s_r.sp;
      endcase
      // Frame order high to low address: pc low, pc high, index, accumulator, flags
      case (s_r.cnt)
         3'h0: mem_wdata_o = s_r.ctx.pc[7:0];
         3'h1: mem_wdata_o = s_r.ctx.pc[15:8];
         3'h2: mem_wdata_o = s_r.ctx.x;
         3'h3: mem_wdata_o = s_r.ctx.a;
         default: mem_wdata_o = s_r.ctx.cc;
      endcase
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_nxt = s_r;
      s_nxt.go = 1'b0;
      s_nxt.wake = 1'b0;

      // Pin sync; a bit moves once stages two and three agree
      s_nxt.s1 = ext_pin_i;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      s_nxt.pf = (s_r.s2 & ~(s_r.s2 ^ s_r.s3)) | (s_r.pf & (s_r.s2 ^ s_r.s3));
      s_nxt.glev_d = glev;

      // Peripheral latches; a new flag beats a same-cycle clear
      s_nxt.pflag_d = src_flag_i;
      s_nxt.plat = (s_r.plat & ~src_clr_i) | (src_flag_i & ~s_r.pflag_d);

      // Edge latches set here, cleared on entry below
      s_nxt.elat = s_r.elat | gev;

      // Trap is remembered until its entry
      if (trap_i) begin
         s_nxt.trap_p = 1'b1;
      end

      // Core driven mask changes
      if (mask_set_i) begin
         s_nxt.ibit = 1'b1;
      end else if (mask_clr_i) begin
         s_nxt.ibit = 1'b0;
      end

      // APB register writes in the access phase
      if (sel_a && pwrite_i) begin
         case (paddr_i)
            mic_pkg::REG_SENS: s_nxt.sens = pwdata_i[7:0];
            mic_pkg::REG_PINEN: s_nxt.pinen = pwdata_i[15:0];
            default: s_nxt.sens = s_r.sens;
         endcase
      end
      // Read data captured in the setup phase
      if (psel_i && !penable_i) begin
         case (paddr_i)
            mic_pkg::REG_SENS: s_nxt.prdata = {24'h000000, s_r.sens};
            mic_pkg::REG_PINEN: s_nxt.prdata = {16'h0000, s_r.pinen};
            mic_pkg::REG_STAT: begin
               s_nxt.prdata = {18'h00000, req};
               s_nxt.prdata[mic_pkg::STAT_IBIT] = s_r.ibit;
               s_nxt.prdata[mic_pkg::STAT_WAIT] = s_r.slp & ~s_r.hlt;
               s_nxt.prdata[mic_pkg::STAT_HALT] = s_r.hlt;
               s_nxt.prdata[mic_pkg::STAT_BUSY] = s_r.st != mic_pkg::ST_IDLE;
            end
            default: s_nxt.prdata = 32'h00000000;
         endcase
      end

      case (s_r.st)
         // Decisions only at an instruction end or while asleep
         mic_pkg::ST_IDLE: begin
            if (instr_end_i && interrupt_return_instruction_i) begin
               s_nxt.st = mic_pkg::ST_POP;
               s_nxt.cnt = 3'h0;
            end else if ((instr_end_i || s_r.slp) &&
                         (take || (s_r.trap_p && !s_r.slp))) begin
               // A trap pending while asleep waits, else slot 0 would be fetched
               // Wake-up pulse only when leaving a low power mode
               s_nxt.wake = s_r.slp;
               s_nxt.slp = 1'b0;
               s_nxt.hlt = 1'b0;
               s_nxt.st = mic_pkg::ST_PUSH;
               s_nxt.cnt = 3'h0;
               s_nxt.ctx = ctx_i;
               if (s_r.trap_p && !s_r.slp) begin
                  s_nxt.vec = mic_pkg::VEC_TRAP;
                  // A new trap in the entry cycle stays pending
                  s_nxt.trap_p = trap_i;
               end else begin
                  s_nxt.vec = pick;
               end
            end else if (instr_end_i && (wait_i || halt_i)) begin
               // Entering a low power mode opens the mask
               s_nxt.slp = 1'b1;
               s_nxt.hlt = halt_i;
               s_nxt.ibit = 1'b0;
            end
         end
         // Save the frame downward, one byte per acknowledge
         mic_pkg::ST_PUSH: begin
            if (mem_ack_i) begin
               s_nxt.sp = s_r.sp - 16'h0001;
               s_nxt.cnt = s_r.cnt + 3'h1;
               if (s_r.cnt == mic_pkg::CTX_BYTES) begin
                  s_nxt.st = mic_pkg::ST_VECH;
               end
            end
         end
         // Vector high byte
         mic_pkg::ST_VECH: begin
            if (mem_ack_i) begin
               s_nxt.ctx.pc[15:8] = mem_rdata_i;
               s_nxt.st = mic_pkg::ST_VECL;
            end
         end
         // Vector low byte, then hand the context back
         mic_pkg::ST_VECL: begin
            if (mem_ack_i) begin
               s_nxt.ctx.pc[7:0] = mem_rdata_i;
               s_nxt.ctx.cc[mic_pkg::CC_IBIT] = 1'b1;
               s_nxt.ibit = 1'b1;
               s_nxt.go = 1'b1;
               s_nxt.st = mic_pkg::ST_IDLE;
               // Served edge latch drops unless a new edge arrives now
               for (int g = 0; g < 4; g++) begin
                  if (s_r.vec == 4'(g + 2)) begin
                     s_nxt.elat[g] = gev[g];
                  end
               end
            end
         end
         // Restore flags, accumulator, index, pc high, pc low
         mic_pkg::ST_POP: begin
            if (mem_ack_i) begin
               s_nxt.sp = s_r.sp + 16'h0001;
               s_nxt.cnt = s_r.cnt + 3'h1;
               case (s_r.cnt)
                  3'h0: s_nxt.ctx.cc = mem_rdata_i;
                  3'h1: s_nxt.ctx.a = mem_rdata_i;
                  3'h2: s_nxt.ctx.x = mem_rdata_i;
                  3'h3: s_nxt.ctx.pc[15:8] = mem_rdata_i;
                  default: begin
                     s_nxt.ctx.pc[7:0] = mem_rdata_i;
                     // Mask bit follows the popped flags
                     s_nxt.ibit = s_r.ctx.cc[mic_pkg::CC_IBIT];
                     s_nxt.go = 1'b1;
                     s_nxt.st = mic_pkg::ST_IDLE;
                  end
               endcase
            end
         end
         default: s_nxt.st = mic_pkg::ST_IDLE;
      endcase
   end

   // ****************************************
   // State register
   // ****************************************
   // Reset starts by fetching the reset vector
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_r <= '0;
         s_r.st <= mic_pkg::ST_VECH;
         s_r.vec <= mic_pkg::VEC_RESET;
         s_r.sp <= mic_pkg::SP_RST;
         s_r.ibit <= 1'b1;
         s_r.ctx.cc <= mic_pkg::CC_RST;
         s_r.sens <= mic_pkg::SENS_RST;
         s_r.pinen <= mic_pkg::PINEN_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign ctx_o = s_r.ctx;
   assign ctx_load_o = s_r.go;
   assign mask_o = s_r.ibit;
   assign wake_o = s_r.wake;
   assign wait_o = s_r.slp & ~s_r.hlt;
   assign halt_o = s_r.hlt;
   assign prdata_o = s_r.prdata;
   // Zero wait states; unknown offsets flag an error
   assign pready_o = sel_a;
   assign pslverr_o = sel_a && (paddr_i != mic_pkg::REG_SENS) &&
                      (paddr_i != mic_pkg::REG_PINEN) &&
                      !((paddr_i == mic_pkg::REG_STAT) && !pwrite_i);

endmodule : mic_ctrl

/* File: tb/mic_ctrl_properties.sv */
`timescale 1ns/1ps
module mic_ctrl_chk (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Core side
   input wire logic instr_end_i,
   input wire logic trap_i,
   input wire logic wait_o,
   input wire logic halt_o,
   input wire logic mask_o,
   input wire mic_pkg::mic_ctx_t ctx_o,
   input wire logic ctx_load_o,
   // Memory side
   input wire logic mem_req_o,
   input wire logic mem_we_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic [7:0] mem_rdata_i,
   input wire logic mem_ack_i
);
   // ****************************************
   // Helper state
   // ****************************************
   logic vf_r, tp_r, hf_r; // Vector fetched, trap pending, slept in halt
   logic [7:0] vh_r, vl_r; // Vector bytes seen on the port
   logic [15:0] va_r; // Last vector byte address
   logic [2:0] nw_r; // Pushes since last load
   logic vrd; // Vector byte read completes
   assign vrd = mem_ack_i && !mem_we_o && (&mem_addr_o[15:5]);
   // Track the sequence from port traffic only
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         vf_r <= 1'b0;
         tp_r <= 1'b0;
         hf_r <= 1'b0;
         nw_r <= 3'h0;
         vh_r <= 8'h00;
         vl_r <= 8'h00;
         va_r <= 16'h0000;
      end else begin
         vf_r <= ctx_load_o ? 1'b0 : (vf_r | vrd);
         tp_r <= trap_i | (tp_r & !(vrd && mem_addr_o == 16'hfffc));
         hf_r <= ctx_load_o ? 1'b0 : (hf_r | halt_o);
         nw_r <= ctx_load_o ? 3'h0 : nw_r + {2'h0, mem_ack_i & mem_we_o};
         // Hi byte at even address, lo at odd
         if (vrd) begin
            va_r <= mem_addr_o;
            if (mem_addr_o[0]) vl_r <= mem_rdata_i;
            else vh_r <= mem_rdata_i;
         end
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // ****************************************
   // Properties
   // ****************************************
   property p_rst;
      $rose(resetn_i) |-> mem_req_o && !mem_we_o && mem_addr_o == 16'hfffe;
   endproperty
   a_rst: assert property (p_rst) else $error("reset fetch wrong");
   property p_end;
      (mem_req_o && mem_we_o && !$past(mem_req_o))
         |-> ($past(instr_end_i) || $past(wait_o) || $past(halt_o));
   endproperty
   a_end: assert property (p_end) else $error("entry mid instruction");
   property p_push;
      ctx_load_o && vf_r && va_r != 16'hffff |-> nw_r == 3'h5;
   endproperty
   a_push: assert property (p_push) else $error("push count wrong");
   property p_mask;
      ctx_load_o && vf_r |-> mask_o && ctx_o.cc[3];
   endproperty
   a_mask: assert property (p_mask) else $error("mask not set on entry");
   property p_pc;
      ctx_load_o && vf_r |-> ctx_o.pc == {vh_r, vl_r};
   endproperty
   a_pc: assert property (p_pc) else $error("pc not from vector");
   property p_unm;
      (mem_req_o && mem_we_o && !$past(mem_req_o)) |-> (!$past(mask_o) || $past(tp_r));
   endproperty
   a_unm: assert property (p_unm) else $error("entry while masked");
   property p_halt;
      hf_r && mem_req_o && !mem_we_o && (&mem_addr_o[15:5])
         |-> mem_addr_o >= 16'hfff0 && mem_addr_o <= 16'hfff9;
   endproperty
   a_halt: assert property (p_halt) else $error("bad halt wake source");
   property p_none;
      mem_req_o && !mem_we_o && (&mem_addr_o[15:5])
         |-> !(mem_addr_o[15:1] inside {15'h7ffd, 15'h7ff7, 15'h7ff1, 15'h7ff0});
   endproperty
   a_none: assert property (p_none) else $error("empty slot fetched");
endmodule : mic_ctrl_chk
bind mic_ctrl mic_ctrl_chk u_chk (.clk_i, .resetn_i, .instr_end_i, .trap_i, .wait_o,
   .halt_o, .mask_o, .ctx_o, .ctx_load_o, .mem_req_o, .mem_we_o, .mem_addr_o,
   .mem_rdata_i, .mem_ack_i);

/* File: tb/mic_mem_model.sv */
`timescale 1ns/1ps
module mic_mem_model (
   // Clock, reset, pace
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic slow_i,
   // Memory port
   input wire logic req_i,
   input wire logic we_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   output logic ack_o
);
   logic [7:0] mem [65536]; // Bytes written by pushes
   logic [65535:0] wr_r; // Written marks; unwritten bytes read as address low byte
   logic [1:0] dly_r; // Wait states when slow
   // One ack per request; data toggles when idle so stale bytes never match
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ack_o <= 1'b0;
         dly_r <= 2'h0;
         rdata_o <= 8'h00;
         wr_r <= '0;
      end else if (req_i && !ack_o && (!slow_i || dly_r == 2'h3)) begin
         ack_o <= 1'b1;
         dly_r <= 2'h0;
         if (we_i) begin
            mem[addr_i] <= wdata_i;
            wr_r[addr_i] <= 1'b1;
         end
         rdata_o <= wr_r[addr_i] ? mem[addr_i] : addr_i[7:0];
      end else begin
         ack_o <= 1'b0;
         dly_r <= (req_i && !ack_o) ? dly_r + 2'h1 : 2'h0;
         rdata_o <= ~rdata_o;
      end
   end
endmodule : mic_mem_model

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
   // ****************************************
   // Signals
   // ****************************************
   logic clk_i = 1'b0, resetn_i = 1'b0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic pready_o, pslverr_o, err, slow = 0;
   logic instr_end_i = 0, trap_i = 0, interrupt_return_instruction_i = 0, wait_i = 0, halt_i = 0;
   logic mask_set_i = 0, mask_clr_i = 0;
   mic_pkg::mic_ctx_t ctx_i = {16'h1234, 8'h56, 8'h78, 8'h00}; // Live core context
   mic_pkg::mic_ctx_t ctx_o, c;
   logic ctx_load_o, mask_o, wake_o, wait_o, halt_o, mem_req_o, mem_we_o, mem_ack_i;
   logic [15:0] mem_addr_o, ext_pin_i = 16'hffff;
   logic [7:0] mem_wdata_o, mem_rdata_i;
   logic [6:0] src_flag_i = 0, src_en_i = 0, src_clr_i = 0;
   logic [15:0] pv [7] = '{16'hf8f9, 16'hf8f9, 16'heced, 16'heaeb, 16'he8e9, 16'he6e7,
      16'he4e5}; // Expected pc per source: vector byte values are their addresses
   logic [7:0] pb [5] = '{8'h34, 8'h12, 8'h56, 8'h78, 8'h00}; // Frame bytes
   int pr [4] = '{3, 2, 4, 6}; // Service order by priority
   int n_errors = 0, n_tests = 0, cyc = 0, n_wake = 0;
   always #2.5 clk_i = ~clk_i;
   mic_ctrl i_dut (.clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .instr_end_i, .trap_i, .interrupt_return_instruction_i, .wait_i, .halt_i,
      .mask_set_i, .mask_clr_i, .ctx_i, .ctx_o, .ctx_load_o, .mask_o, .wake_o, .wait_o,
      .halt_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .mem_ack_i,
      .src_flag_i, .src_en_i, .src_clr_i, .ext_pin_i);
   mic_mem_model i_mem (.clk_i, .resetn_i, .slow_i(slow), .req_i(mem_req_o),
      .we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i),
      .ack_o(mem_ack_i));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
   endtask : apb
   // Instruction end with qualifiers {interrupt_return_instruction, wait, halt}
   task automatic pulse(input logic [2:0] s);
      @(posedge clk_i);
      {instr_end_i, interrupt_return_instruction_i, wait_i, halt_i} <= {1'b1, s};
      @(posedge clk_i);
      {instr_end_i, interrupt_return_instruction_i, wait_i, halt_i} <= 4'h0;
   endtask : pulse
   task automatic msk(input logic set);
      @(posedge clk_i);
      {mask_set_i, mask_clr_i} <= {set, !set};
      @(posedge clk_i);
      {mask_set_i, mask_clr_i} <= 2'b00;
   endtask : msk
   task automatic flag(input int i);
      @(posedge clk_i);
      src_flag_i[i] <= 1;
   endtask : flag
   // Clear sequence: flag drops in the same cycle as a one-cycle clear pulse
   task automatic clr(input int i);
      @(posedge clk_i);
      src_flag_i[i] <= 0;
      src_clr_i[i] <= 1;
      @(posedge clk_i);
      src_clr_i[i] <= 0;
   endtask : clr
   // Wait for a context load and check an entry
   task automatic ld(input logic [15:0] pc);
      do @(posedge clk_i); while (ctx_load_o !== 1'b1);
      c = ctx_o;
      chk(c.pc, pc);
      chk(c.cc[3], 1);
      chk(mask_o, 1);
   endtask : ld
   task automatic ent(input logic [15:0] pc);
      pulse(3'b000);
      ld(pc);
   endtask : ent
   task automatic ret;
      pulse(3'b100);
      do @(posedge clk_i); while (ctx_load_o !== 1'b1);
      chk(ctx_o[39:8], ctx_i[39:8]);
      chk(ctx_o.cc, ctx_i.cc);
      @(posedge clk_i);
      chk(mask_o, 0);
   endtask : ret
   // No memory traffic may start for twelve cycles
   task automatic none;
      logic b;
      b = 0;
      repeat (12) begin
         @(posedge clk_i);
         b |= (mem_req_o !== 1'b0);
      end
      chk(b, 0);
   endtask : none
   task automatic give_verdict;
      $display("checks %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : give_verdict
   // Hang guard, far beyond the planned run
   always @(posedge clk_i) begin
      cyc++;
      // Wake pulses, counted for the sleep scenarios
      if (wake_o === 1'b1) n_wake++;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict;
      end
   end
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      repeat (16) @(posedge clk_i);
      resetn_i <= 1;
      ld(16'hfeff);
      chk(c.cc, 8'h08);
      apb(1, 8'h0c, 1);
      chk(err, 1);
      apb(1, 8'h08, 0);
      chk(err, 1);
      apb(0, 8'h00, 0);
      chk(rd[7:0], 8'h00);
      $display("reset test done");
      src_en_i <= 7'h7f;
      msk(0);
      for (int i = 0; i < 7; i++) begin
         slow <= i[0];
         flag(i);
         ent(pv[i]);
         for (int j = 0; j < 5 && i == 0; j++) chk(i_mem.mem[511 - j], pb[j]);
         clr(i);
         ret;
      end
      @(posedge clk_i);
      src_flag_i <= 7'h58;
      for (int k = 0; k < 4; k++) begin
         ent(pv[pr[k]]);
         if (k == 0) begin
            flag(2);
            pulse(3'b000);
            none;
         end
         clr(pr[k]);
         ret;
      end
      $display("priority test done");
      src_en_i[5] <= 0;
      flag(5);
      pulse(3'b000);
      none;
      clr(5);
      src_en_i[5] <= 1;
      pulse(3'b000);
      none;
      msk(1);
      flag(3);
      pulse(3'b000);
      none;
      msk(0);
      ent(16'heaeb);
      clr(3);
      ret;
      msk(1);
      @(posedge clk_i) trap_i <= 1;
      @(posedge clk_i) trap_i <= 0;
      ent(16'hfcfd);
      ret;
      pulse(3'b010);
      @(posedge clk_i);
      chk(wait_o, 1);
      flag(4);
      ld(16'he8e9);
      chk(wait_o, 0);
      chk(n_wake, 1);
      clr(4);
      ret;
      $display("mask trap wait test done");
      apb(1, 8'h04, 32'h1131);
      apb(0, 8'h04, 0);
      chk(rd[15:0], 16'h1131);
      for (int g = 0; g < 4; g++) begin
         apb(1, 8'h00, 32'h36);
         if (g == 0) begin
            pulse(3'b001);
            flag(3);
            none;
            chk(halt_o, 1);
         end
         if (g == 1) begin
            @(posedge clk_i) ext_pin_i[5:4] <= 2'b00;
            @(posedge clk_i) ext_pin_i[4] <= 1;
            // Let the pin synchroniser settle before the instruction end
            repeat (6) @(posedge clk_i);
            pulse(3'b000);
            none;
            @(posedge clk_i) ext_pin_i[5] <= 1;
         end else begin
            @(posedge clk_i) ext_pin_i[4 * g] <= 0;
         end
         if (g == 0) begin
            ld(16'hf6f7);
            chk(n_wake, 2);
         end else begin
            repeat (6) @(posedge clk_i);
            ent(16'hf6f7 - 16'h0202 * 16'(g));
         end
         apb(1, 8'h00, 32'haa);
         @(posedge clk_i) ext_pin_i <= 16'hffff;
         if (g == 0) clr(3);
         ret;
         pulse(3'b000);
         none;
      end
      $display("external test done");
      give_verdict;
   end
endmodule : testbench
